// File: hw/vdram_defines.svh
`ifndef VDRAM_DEFINES_SVH
`define VDRAM_DEFINES_SVH

// ********************************************************
// Geometry
// ********************************************************
`define ROW_W          9
`define COL_W          8
`define DQ_W           8
`define ROW_COUNT      10'h200

// ********************************************************
// Timing, 50 MHz clock (20 ns)
// ********************************************************
`define CLK_PERIOD_NS  20
`define REFRESH_MS     8
// Whole refresh period in cycles, rounded down
`define REFRESH_PERIOD_CYC ((`REFRESH_MS * 1000000) / `CLK_PERIOD_NS)
// One refresh slot: period divided by the row count, rounded down
`define REFRESH_SLOT_CYC   (`REFRESH_PERIOD_CYC / 512)
// Last phase count value; each strobe phase lasts PH_CYC + 1 cycles
`define PH_CYC         3'h2

`endif

// File: hw/vdram_pkg.sv
package vdram_pkg;

  // ********************************************************
  // Command kinds
  // ********************************************************
  typedef enum logic [2:0] {
    OP_READ       = 3'h0,
    OP_WRITE      = 3'h1,
    OP_BLOCK      = 3'h2,
    OP_LOAD_MASK  = 3'h3,
    OP_LOAD_COLOR = 3'h4
  } op_e;

  // Request from the user side
  typedef struct packed {
    op_e        op;
    logic       masked;      // Write-per-bit used
    logic       reload_mask; // New mask given with this write
    logic [7:0] mask;
    logic [8:0] row;
    logic [7:0] col;
    logic [7:0] data;        // Data, colour, mask or column select
  } req_s;

  // Pins towards the memory
  typedef struct packed {
    logic       row_strobe_n;
    logic       col_strobe_n;
    logic       store_enable_n;
    logic       transfer_output_gate_n;
    logic       shift_port_gate_n;
    logic       special_function_select;
    logic [8:0] multiplexed_addr_lines;
  } pins_s;

endpackage

// File: hw/refresh_timer.sv
`timescale 1ns/10ps
`include "vdram_defines.svh"

// ********************************************************
// Refresh slot timer and owed refresh tally
// ********************************************************
module refresh_timer #(
  parameter int SLOT_CYC = `REFRESH_SLOT_CYC
) (
  input  wire logic clk,    // System clock
  input  wire logic rst,    // Synchronous reset
  input  wire logic served, // One refresh cycle done
  output logic      due     // A refresh is owed
);

  logic [31:0] cnt_r;
  logic [3:0]  owed_r;

  // Slot counter
  always_ff @(posedge clk) begin
    if (rst || cnt_r == 32'(SLOT_CYC - 1)) begin
      cnt_r <= 32'h0;
    end else begin
      cnt_r <= cnt_r + 32'h1;
    end
  end

  // Owed refreshes, saturating at 15; a tick and a service in one cycle cancel
  always_ff @(posedge clk) begin
    if (rst) begin
      owed_r <= 4'h0;
    end else if (cnt_r == 32'(SLOT_CYC - 1) && !served) begin
      owed_r <= (owed_r == 4'hF) ? owed_r : owed_r + 4'h1;
    end else if (cnt_r != 32'(SLOT_CYC - 1) && served && owed_r != 4'h0) begin
      owed_r <= owed_r - 4'h1;
    end
  end

  assign due = (owed_r != 4'h0);

endmodule // refresh_timer

// File: hw/vdram_host.sv
`timescale 1ns/10ps
`include "vdram_defines.svh"

// Operation
// - Drive the nine-bit row address before the row strobe falls.
// - Drive the eight-bit column address before the column strobe falls.
// - Colour load is a write with select high at both strobe falls.
// - Refresh every row at least once per eight milliseconds.
// - Row-only refresh steps 512 rows with column strobe high; the host uses CBR refresh with column strobe low instead.
// - Keep the transfer gate high at row strobe fall for random access.

module vdram_host #(
  parameter int REFRESH_SLOT = `REFRESH_SLOT_CYC
) (
  input  wire logic              clk,        // System clock
  input  wire logic              rst,        // Synchronous reset
  input  wire vdram_pkg::req_s   req,        // Request fields
  input  wire logic              req_valid,  // Request offered
  output logic                   req_ready,  // Request taken
  output logic [7:0]             rd_data,    // Read data
  output logic                   rd_valid,   // Read data pulse
  output vdram_pkg::pins_s       pins,       // Strobes and address
  output logic [7:0]             dq_out,     // Data pin drive value
  output logic                   dq_oe,      // Data pin drive enable
  input  wire logic [7:0]        dq_in       // Data pin level
);

  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_ROW  = 6'b000010,
    ST_RLOW = 6'b000100,
    ST_COL  = 6'b001000,
    ST_CLOW = 6'b010000,
    ST_PRE  = 6'b100000
  } state_e;

  state_e             state_r;
  vdram_pkg::req_s    cur_r;
  logic               cbr_r;       // Current cycle is a refresh
  logic [2:0]         ph_r;
  logic [7:0]         dq_s1_r;
  logic [7:0]         dq_s2_r;
  logic               due;
  logic               served;
  logic               is_write;
  logic               ph_done;

  // ********************************************************
  // Refresh scheduling
  // ********************************************************
  refresh_timer #(
    .SLOT_CYC (REFRESH_SLOT)
  ) u_refresh (
    .clk    (clk),
    .rst    (rst),
    .served (served),
    .due    (due)
  );

  assign served   = (state_r == ST_PRE) && ph_done && cbr_r;
  assign ph_done  = (ph_r == `PH_CYC);
  assign is_write = (cur_r.op != vdram_pkg::OP_READ);
  assign req_ready = (state_r == ST_IDLE) && !due;

  // ********************************************************
  // Data pin synchroniser
  // ********************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      dq_s1_r <= 8'h00;
      dq_s2_r <= 8'h00;
    end else begin
      dq_s1_r <= dq_in;
      dq_s2_r <= dq_s1_r;
    end
  end

  // Phase counter restarts at every state change
  always_ff @(posedge clk) begin
    if (rst || state_r == ST_IDLE || ph_done) begin
      ph_r <= 3'h0;
    end else begin
      ph_r <= ph_r + 3'h1;
    end
  end

  // ********************************************************
  // Cycle sequencer
  // ********************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= ST_IDLE;
      cbr_r   <= 1'b0;
      cur_r   <= '0;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (due) begin
            cbr_r   <= 1'b1;
            state_r <= ST_COL;
          end else if (req_valid) begin
            cbr_r   <= 1'b0;
            cur_r   <= req;
            state_r <= ST_ROW;
          end
        end
        ST_ROW:  if (ph_done) state_r <= ST_RLOW;   // Row address setup
        ST_RLOW: if (ph_done) state_r <= cbr_r ? ST_PRE : ST_COL;
        ST_COL:  if (ph_done) state_r <= cbr_r ? ST_RLOW : ST_CLOW;
        ST_CLOW: if (ph_done) state_r <= ST_PRE;
        ST_PRE:  if (ph_done) state_r <= ST_IDLE;
      endcase
    end
  end

  // ********************************************************
  // Pin drive
  // ********************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      pins.row_strobe_n            <= 1'b1;
      pins.col_strobe_n            <= 1'b1;
      pins.store_enable_n          <= 1'b1;
      pins.transfer_output_gate_n  <= 1'b1;
      pins.shift_port_gate_n       <= 1'b1;
      pins.special_function_select <= 1'b0;
      pins.multiplexed_addr_lines  <= 9'h000;
      dq_out                       <= 8'h00;
      dq_oe                        <= 1'b0;
    end else begin
      pins.shift_port_gate_n <= 1'b1;
      unique case (state_r)
        ST_IDLE: begin
          pins.row_strobe_n           <= 1'b1;
          pins.col_strobe_n           <= 1'b1;
          pins.store_enable_n         <= 1'b1;
          pins.transfer_output_gate_n <= 1'b1;
          dq_oe                       <= 1'b0;
        end
        ST_ROW: begin
          pins.multiplexed_addr_lines  <= cur_r.row;
          // Row-fall levels choose the cycle type
          pins.store_enable_n          <= !(is_write && cur_r.masked);
          pins.special_function_select <=
            (cur_r.op == vdram_pkg::OP_LOAD_MASK) ||
            (cur_r.op == vdram_pkg::OP_LOAD_COLOR) ||
            (cur_r.masked && !cur_r.reload_mask);
          pins.transfer_output_gate_n  <= 1'b1;
          dq_out                       <= cur_r.mask;
          dq_oe                        <= is_write && cur_r.masked && cur_r.reload_mask;
          if (ph_done) begin
            pins.row_strobe_n <= 1'b0;
          end
        end
        ST_RLOW: begin
          // Internal row counter stands in for stepping all rows by address
          if (cbr_r) begin
            pins.row_strobe_n <= 1'b0;
          end
          dq_oe <= 1'b0;
        end
        ST_COL: begin
          if (cbr_r) begin
            pins.col_strobe_n <= 1'b0;
          end else begin
            pins.multiplexed_addr_lines <= {1'b0, cur_r.col};
            pins.special_function_select <=
              (cur_r.op == vdram_pkg::OP_BLOCK) ||
              (cur_r.op == vdram_pkg::OP_LOAD_COLOR);
            // Gate low only for reads, else it enables the device outputs
            pins.transfer_output_gate_n <= is_write;
            pins.store_enable_n         <= !is_write;
            dq_out                      <= cur_r.data;
            dq_oe                       <= is_write;
            if (ph_done) begin
              pins.col_strobe_n <= 1'b0;
            end
          end
        end
        ST_CLOW: begin
          pins.col_strobe_n <= 1'b0;
        end
        ST_PRE: begin
          pins.row_strobe_n           <= 1'b1;
          pins.col_strobe_n           <= 1'b1;
          pins.store_enable_n         <= 1'b1;
          pins.transfer_output_gate_n <= 1'b1;
          dq_oe                       <= 1'b0;
        end
      endcase
    end
  end

  // ********************************************************
  // Read capture at the end of the column-low phase
  // ********************************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_data  <= 8'h00;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= 1'b0;
      if (state_r == ST_CLOW && ph_done && !is_write && !cbr_r) begin
        rd_data  <= dq_s2_r;
        rd_valid <= 1'b1;
      end
    end
  end

endmodule // vdram_host

// File: verif/vdram_host_checker.sv
`timescale 1ns/10ps
// ********
// Pin protocol checks
// ********
module vdram_host_checker #(
  parameter int SLOT = 50
) (
  input wire logic             clk,      // System clock
  input wire logic             rst,      // Synchronous reset
  input wire logic             rd_valid, // Read pulse
  input wire vdram_pkg::pins_s pins,     // Strobes and address
  input wire logic             dq_oe     // Data drive enable
);
  logic [15:0] gap_r; // Cycles since last refresh
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence cbr_col; $fell(pins.col_strobe_n) && pins.row_strobe_n; endsequence
  sequence cbr_row; $fell(pins.row_strobe_n) && !pins.col_strobe_n; endsequence
  // Refresh gap counter
  always_ff @(posedge clk) begin
    if (rst || ($fell(pins.row_strobe_n) && !pins.col_strobe_n)) begin
      gap_r <= 16'h0000;
    end else begin
      gap_r <= gap_r + 16'h0001;
    end
  end
  a_row_addr_hold: assert property ($fell(pins.row_strobe_n) |->
    $stable(pins.multiplexed_addr_lines)) else $error("row address moved");
  a_col_addr_hold: assert property ($fell(pins.col_strobe_n) && !pins.row_strobe_n
    |-> $stable(pins.multiplexed_addr_lines)) else $error("column address moved");
  a_gate_at_row: assert property ($fell(pins.row_strobe_n) |->
    pins.transfer_output_gate_n) else $error("gate low at row fall");
  a_sfs_at_col: assert property ($fell(pins.col_strobe_n) |->
    $stable(pins.special_function_select)) else $error("select moved");
  a_read_bus_free: assert property (!pins.row_strobe_n && !pins.col_strobe_n
    && !pins.transfer_output_gate_n |-> !dq_oe) else $error("host drives in read");
  a_write_data_on: assert property ($fell(pins.col_strobe_n) && !pins.row_strobe_n
    && !pins.store_enable_n |-> dq_oe && pins.transfer_output_gate_n)
    else $error("write data missing");
  a_mask_on_pins: assert property ($fell(pins.row_strobe_n) && !pins.store_enable_n
    && !pins.special_function_select |-> dq_oe) else $error("mask not driven");
  a_cbr_order: assert property (cbr_col |-> ##[1:8] cbr_row)
    else $error("refresh row strobe late");
  a_refresh_gap: assert property (gap_r < 2 * SLOT)
    else $error("refresh overdue");
  a_rd_one_cycle: assert property (rd_valid |=> !rd_valid)
    else $error("read pulse too long");
endmodule // vdram_host_checker

bind vdram_host vdram_host_checker #(.SLOT(REFRESH_SLOT)) u_vdram_host_checker (
  .clk(clk), .rst(rst), .rd_valid(rd_valid), .pins(pins), .dq_oe(dq_oe));

// File: verif/vdram_model.sv
`timescale 1ns/10ps
// ********
// Behavioural memory random port
// ********
module vdram_model (
  input  wire logic             clk,    // Paces the idle pattern
  input  wire vdram_pkg::pins_s pins,   // Strobes and address
  input  wire logic [7:0]       dq_out, // Host drive value
  input  wire logic             dq_oe,  // Host drive enable
  output logic [7:0]            dq_in   // Resolved pin level
);
  logic [7:0] mem [int];
  logic [7:0] mask_r, color_r, q_r, last_r = 8'h00;
  logic [8:0] row_r, ref_cnt = 9'h000;
  logic [7:0] col_r;
  logic       wpb_r, cfg_r, csfs_r, trg_r, dev_oe;
  // Stores data as the cycle type asks
  task put(input logic [7:0] d);
    logic [7:0] m;
    m = wpb_r ? mask_r : 8'hFF;
    if (cfg_r && csfs_r) color_r = d;
    else if (cfg_r) mask_r = d;
    else if (csfs_r) begin
      for (int k = 0; k < 4; k++) begin
        if (d[k]) mem[{row_r, col_r[7:2], 2'(k)}] = color_r;
      end
    end else mem[{row_r, col_r}] = (mem[{row_r, col_r}] & ~m) | (d & m);
  endtask
  // Row fall: refresh or latch row and cycle type
  always @(negedge pins.row_strobe_n) begin
    if (!pins.col_strobe_n) begin
      ref_cnt = ref_cnt + 9'h001;
    end else begin
      row_r = pins.multiplexed_addr_lines;
      trg_r = pins.transfer_output_gate_n;
      wpb_r = !pins.store_enable_n;
      cfg_r = pins.store_enable_n && pins.special_function_select;
      if (!pins.store_enable_n && !pins.special_function_select) mask_r = dq_in;
    end
  end
  // Column fall latches column; data at the later falling strobe
  always @(negedge pins.col_strobe_n) begin
    if (!pins.row_strobe_n) begin
      col_r = pins.multiplexed_addr_lines[7:0];
      csfs_r = pins.special_function_select;
      q_r = mem.exists({row_r, col_r}) ? mem[{row_r, col_r}] : 8'h00;
      if (!pins.store_enable_n) put(dq_in);
    end
  end
  // Delayed write strobed by store-enable
  always @(negedge pins.store_enable_n) begin
    if (!pins.row_strobe_n && !pins.col_strobe_n) put(dq_in);
  end
  // Released pins show the inverse of the last driven byte
  always @(posedge clk) begin
    if (dq_oe === 1'b1 || dev_oe === 1'b1) last_r <= dq_in;
  end
  // Drive only in a read with column strobe and gate low
  assign dev_oe = !pins.row_strobe_n && !pins.col_strobe_n && trg_r
    && !pins.transfer_output_gate_n && pins.store_enable_n;
  assign dq_in = dq_oe ? dq_out : (dev_oe ? q_r : ~last_r);
endmodule // vdram_model

// File: verif/testbench.sv
`timescale 1ns/10ps
module testbench;
  logic             clk, rst, req_valid, req_ready, rd_valid, dq_oe;
  logic [7:0]       rd_data, dq_out, dq_in;
  vdram_pkg::req_s  req;
  vdram_pkg::pins_s pins;
  int               err_total = 0;
  int               num_checks = 0;

  vdram_host #(.REFRESH_SLOT(50)) u_vdram_host (.clk(clk), .rst(rst), .req(req),
    .req_valid(req_valid), .req_ready(req_ready), .rd_data(rd_data), .rd_valid(rd_valid),
    .pins(pins), .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in));
  vdram_model u_vdram_model (.clk(clk), .pins(pins), .dq_out(dq_out), .dq_oe(dq_oe),
    .dq_in(dq_in));

  // Clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task end_sim;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Offers one request and holds it until taken
  task send(input vdram_pkg::op_e o, input logic m, input logic rl, input logic [7:0] mk,
            input logic [8:0] r, input logic [7:0] c, input logic [7:0] d);
    int n;
    @(posedge clk);
    req <= '{o, m, rl, mk, r, c, d};
    req_valid <= 1'b1;
    n = 0;
    @(negedge clk);
    while (req_ready !== 1'b1 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    if (req_ready !== 1'b1) err_total++;
    @(posedge clk);
    req_valid <= 1'b0;
  endtask

  task wr(input logic [8:0] r, input logic [7:0] c, input logic [7:0] d);
    send(vdram_pkg::OP_WRITE, 1'b0, 1'b0, 8'h00, r, c, d);
  endtask

  task rd(input logic [8:0] r, input logic [7:0] c, input logic [7:0] e);
    int n;
    send(vdram_pkg::OP_READ, 1'b0, 1'b0, 8'h00, r, c, 8'h00);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (rd_valid !== 1'b1 && n < 100);
    if (rd_valid !== 1'b1) err_total++;
    chk(rd_data, e);
  endtask

  // Back-to-back writes at the top address and at row 1
  task t_plain;
    wr(9'h001, 8'h02, 8'h5A);
    wr(9'h1FF, 8'hFF, 8'hA5);
    wr(9'h001, 8'h03, 8'h3C);
    rd(9'h001, 8'h02, 8'h5A);
    rd(9'h1FF, 8'hFF, 8'hA5);
    rd(9'h001, 8'h03, 8'h3C);
  endtask

  // Reloaded, persistent and unmasked writes
  task t_mask;
    wr(9'h003, 8'h04, 8'hFF);
    wr(9'h003, 8'h05, 8'h00);
    send(vdram_pkg::OP_WRITE, 1'b1, 1'b1, 8'h0F, 9'h003, 8'h04, 8'h00);
    rd(9'h003, 8'h04, 8'hF0);
    send(vdram_pkg::OP_WRITE, 1'b1, 1'b0, 8'h00, 9'h003, 8'h05, 8'hFF);
    rd(9'h003, 8'h05, 8'h0F);
    wr(9'h003, 8'h04, 8'h33);
    rd(9'h003, 8'h04, 8'h33);
  endtask

  // Mask load leaves memory alone and feeds later writes
  task t_ldmask;
    wr(9'h003, 8'h06, 8'h00);
    send(vdram_pkg::OP_LOAD_MASK, 1'b0, 1'b0, 8'h00, 9'h003, 8'h04, 8'hC3);
    rd(9'h003, 8'h04, 8'h33);
    send(vdram_pkg::OP_WRITE, 1'b1, 1'b0, 8'h00, 9'h003, 8'h06, 8'hFF);
    rd(9'h003, 8'h06, 8'hC3);
  endtask

  // Colour load and block writes with column select
  task t_block;
    for (int k = 0; k < 4; k++) wr(9'h005, {6'h04, 2'(k)}, 8'h11);
    send(vdram_pkg::OP_LOAD_COLOR, 1'b0, 1'b0, 8'h00, 9'h005, 8'h00, 8'h96);
    send(vdram_pkg::OP_BLOCK, 1'b0, 1'b0, 8'h00, 9'h005, 8'h12, 8'h05);
    for (int k = 0; k < 4; k++) rd(9'h005, {6'h04, 2'(k)}, k[0] ? 8'h11 : 8'h96);
    send(vdram_pkg::OP_BLOCK, 1'b0, 1'b0, 8'h00, 9'h005, 8'h11, 8'h08);
    rd(9'h005, 8'h13, 8'h96);
  endtask

  // Main sequence
  initial begin
    rst = 1'b1;
    req = '0;
    req_valid = 1'b0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_plain;
    t_mask;
    t_ldmask;
    t_block;
    chk({7'h00, |u_vdram_model.ref_cnt}, 8'h01);
    end_sim;
  end

  // Watchdog
  initial begin
    #400000;
    err_total++;
    end_sim;
  end
endmodule // testbench
